// >>> shared/dmatms_pkg.sv
// Package of constants and types for the DMA transfer-mode sequencer
//==========================================================================
// What this block does
// RL1: Repeat enable low selects sequential mode
// RL2: Sequential: one item per request, then address update
// RL3: Direction picks which address is source
// RL4: IO address upper eight bits forced to ones
// RL5: Count decrements per transfer, ends at zero
// RL6: Memory address steps one or two bytes
// RL7: Count range one to 65,536 transfers
// RL8: Repeat: 1 to 256, reload address and count
// RL9: Single address: one bus cycle, acknowledge pin
// RL10: External request and single address: B only; in full mode the pin serves any channel
// RL11: Auto-request runs whole count, burst or steal
// RL12: Block mode moves whole block per request
// RL13: Short modes move one item per request
// RL14: Idle mode keeps memory address fixed
// RL15: At zero clear enable, raise end interrupt
// RL16: Programmed zero count means 65,536 transfers
// RL17: IO address never modified by transfers
`default_nettype none
package dmatms_pkg;
  //==========================================================================
  // Register map (byte addresses, one word each)
  localparam logic [7:0] ADDR_MEM    = 8'h00; // Memory address
  localparam logic [7:0] ADDR_IO     = 8'h04; // IO address
  localparam logic [7:0] ADDR_COUNT  = 8'h08; // Transfer count
  localparam logic [7:0] ADDR_CTRL   = 8'h0c; // Channel control
  localparam logic [7:0] ADDR_STAT   = 8'h10; // Interrupt status
  localparam logic [7:0] ADDR_MASK   = 8'h14; // Interrupt mask
  localparam logic [7:0] ADDR_BLOCK  = 8'h18; // Block size
  // Control field positions
  localparam int CTL_EN     = 0;  // Channel enable
  localparam int CTL_RPT    = 1;  // Repeat enable
  localparam int CTL_IRQEN  = 2;  // Transfer end irq enable
  localparam int CTL_DIR    = 3;  // Transfer direction
  localparam int CTL_WORD   = 4;  // Word size
  localparam int CTL_DEC    = 5;  // Decrement address
  localparam int CTL_FULL   = 6;  // Full address mode
  localparam int CTL_BLKM   = 7;  // Block transfer mode
  localparam int CTL_AUTO   = 8;  // Auto-request
  localparam int CTL_BURST  = 9;  // Burst instead of cycle steal
  localparam int CTL_SINGLE = 10; // Single address mode
  localparam int CTL_BCHAN  = 11; // Channel is a B channel
  localparam int CTL_BLKDST = 12; // Block area is destination
  localparam int CTL_W      = 13; // Control width
  // Status bits
  localparam int ST_END  = 0; // Transfer end event
  localparam int ST_XFER = 1; // One transfer done event
  localparam int ST_W    = 2;
  // Reset values
  localparam logic [CTL_W-1:0] CTL_RESET = 13'h0000;
  localparam logic [7:0]       IO_UPPER  = 8'hff; // Forced upper address
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_READ = 4'h2,
    ST_WRIT = 4'h4,
    ST_NEXT = 4'h8
  } dmatms_state_t;
endpackage
`default_nettype wire

// >>> core/dmatms_addr_step.sv
// Address and count step arithmetic for one transfer
`default_nettype none
module dmatms_addr_step (
  // Current values
  input  wire logic [23:0] memAddr,
  input  wire logic [15:0] count,
  // Mode
  input  wire logic        wordSize,
  input  wire logic        decrement,
  input  wire logic        fixedAddr,
  // Next values
  output logic      [23:0] memAddrNext,
  output logic      [15:0] countNext
);
  // Step size one or two
  logic [23:0] step;
  assign step = wordSize ? 24'h000002 : 24'h000001; // RL6
  // Address stepping, held in idle mode
  assign memAddrNext = fixedAddr ? memAddr :           // RL14
                       decrement ? memAddr - step : memAddr + step; // RL6
  // Count wraps from zero to ffff, so zero means 65,536
  assign countNext = count - 16'h0001; // RL5 RL16
endmodule
`default_nettype wire

// >>> core/dmatms_seq.sv
// DMA transfer-mode sequencer with AXI4-Lite registers and bus master port
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`default_nettype none
module dmatms_seq (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // AXI4-Lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // AXI4-Lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // AXI4-Lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Transfer request pin, active low
  input  wire logic        xferReqN,
  // System bus cycles
  output logic [23:0]      busAddr,
  output logic             busRead,
  output logic             busWrite,
  output logic             busWord,
  output logic [15:0]      busWdata,
  input  wire logic [15:0] busRdata,
  input  wire logic        busDone,
  // Bus released between steal cycles
  output logic             busHold,
  // Acknowledge strobe, active low
  output logic             transferAcknowledgePinN,
  // Interrupt
  output logic             irq
);
  //==========================================================================
  // State
  typedef struct packed {
    logic [23:0] memAddr;      // memory_address
    logic [23:0] memStart;     // Restore value for repeat
    logic [15:0] ioAddr;       // io_address
    logic [15:0] count;        // transfer_count
    logic [7:0]  blkSize;      // Block size, zero means 256
    logic [7:0]  blkLeft;      // Items left in block
    logic [12:0] ctrl;         // channel_control_reg
    logic [1:0]  stat;         // Sticky status
    logic [1:0]  mask;         // Interrupt mask
    logic [15:0] data;         // Latched transfer data
    logic        inBlock;      // Block in progress
    dmatms_pkg::dmatms_state_t st; // Sequencer state
    logic [2:0]  reqSync;      // Request synchroniser
    logic        reqLvl;       // Filtered request level (high active)
    logic        reqPend;      // Edge request pending
    logic        awHave;       // Write address held
    logic [7:0]  awA;
    logic        wHave;        // Write data held
    logic [31:0] wD;
    logic [3:0]  wS;
    logic        bv;
    logic [1:0]  br;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rr;
  } dmatms_regs_t;

  dmatms_regs_t s_q, s_d;

  // Step arithmetic outputs
  logic [23:0] memNext;
  logic [15:0] cntNext;
  logic        repeatMode, fullMode, autoReq, singleAddr, trigger, lastXfer;

  //==========================================================================
  // Control decode
  // Repeat proper needs end irq enable clear; with it set the channel idles
  assign repeatMode = s_q.ctrl[dmatms_pkg::CTL_RPT] & ~s_q.ctrl[dmatms_pkg::CTL_IRQEN]
                      & ~fullMode;                                 // RL1
  assign fullMode   = s_q.ctrl[dmatms_pkg::CTL_FULL];
  assign autoReq    = fullMode & ~s_q.ctrl[dmatms_pkg::CTL_BLKM]
                      & s_q.ctrl[dmatms_pkg::CTL_AUTO];            // RL11
  // Single address only on B channels in short mode
  assign singleAddr = s_q.ctrl[dmatms_pkg::CTL_SINGLE] & s_q.ctrl[dmatms_pkg::CTL_BCHAN]
                      & ~fullMode;                                 // RL10
  // Requests taken from the pin only on B channels or full mode
  assign trigger = autoReq | (s_q.reqPend
                   & (fullMode | s_q.ctrl[dmatms_pkg::CTL_BCHAN])); // RL10 RL13
  // Last of a repeat run counts the low byte only
  assign lastXfer = repeatMode ? (s_q.count[7:0] == 8'h01) : (s_q.count == 16'h0001);

  // Step unit; idle mode when repeat enable with end irq enable in short mode
  dmatms_addr_step u_step (
    .memAddr     (s_q.memAddr),
    .count       (s_q.count),
    .wordSize    (s_q.ctrl[dmatms_pkg::CTL_WORD]),
    .decrement   (s_q.ctrl[dmatms_pkg::CTL_DEC]),
    .fixedAddr   (~fullMode & s_q.ctrl[dmatms_pkg::CTL_RPT] & s_q.ctrl[dmatms_pkg::CTL_IRQEN]),
    .memAddrNext (memNext),
    .countNext   (cntNext)
  );

  // Repeat only when end irq disabled
  logic rptReload;
  assign rptReload = repeatMode & ~s_q.ctrl[dmatms_pkg::CTL_IRQEN];

  // Source address: memory side when direction low
  // Single address mode bypasses this and shows the memory side
  function automatic logic [23:0] pickAddr(input logic dir, input logic src,
                                           input logic [23:0] m, input logic [15:0] io);
    pickAddr = (dir ^ src) ? m : {dmatms_pkg::IO_UPPER, io}; // RL3 RL4
  endfunction

  //==========================================================================
  // Next state
  always_comb begin
    logic doW;
    logic [31:0] wm;
    logic [1:0]  evt;
    doW = 1'b0;
    wm  = 32'h00000000;
    evt = 2'h0;
    s_d = s_q;
    // Request synchroniser and edge detect on agreed levels
    // A pin change counts only once the last two flops agree,
    // so a glitch shorter than a cycle never makes a request
    s_d.reqSync = {s_q.reqSync[1:0], xferReqN};
    if (s_q.reqSync[1] == s_q.reqSync[2]) begin
      s_d.reqLvl = ~s_q.reqSync[2];
      if (~s_q.reqSync[2] & ~s_q.reqLvl) begin
        s_d.reqPend = 1'b1;
      end
    end
    // Sequencer
    case (s_q.st)
      // Wait for an enabled request or the rest of a block
      dmatms_pkg::ST_IDLE: begin
        if (s_q.ctrl[dmatms_pkg::CTL_EN] & (trigger | s_q.inBlock)) begin
          s_d.reqPend = 1'b0;
          if (fullMode & s_q.ctrl[dmatms_pkg::CTL_BLKM] & ~s_q.inBlock) begin
            s_d.inBlock = 1'b1;                                     // RL12
            s_d.blkLeft = s_q.blkSize;
          end
          s_d.st = singleAddr ? dmatms_pkg::ST_WRIT : dmatms_pkg::ST_READ; // RL9
        end
      end
      // Source read; data latched when the bus answers
      dmatms_pkg::ST_READ: begin
        if (busDone) begin
          s_d.data = busRdata;
          s_d.st   = dmatms_pkg::ST_WRIT;
        end
      end
      // Destination write, or the one acknowledged cycle
      dmatms_pkg::ST_WRIT: begin
        if (busDone) begin
          s_d.st = dmatms_pkg::ST_NEXT;
        end
      end
      dmatms_pkg::ST_NEXT: begin
        // Memory side steps; IO address untouched
        s_d.memAddr = memNext;                                      // RL2 RL6 RL17
        s_d.stat[dmatms_pkg::ST_XFER] = 1'b1;
        evt[dmatms_pkg::ST_XFER]      = 1'b1;
        s_d.st = dmatms_pkg::ST_IDLE;
        // Block items step the address, not the count
        if (s_q.inBlock) begin
          s_d.blkLeft = s_q.blkLeft - 8'h01;
          if (s_q.blkLeft != 8'h01) begin
            s_d.st = dmatms_pkg::ST_IDLE;                           // RL12
          end else begin
            s_d.inBlock = 1'b0;
          end
        end
        // Count steps once per request, or once per whole block
        if (~s_q.inBlock | (s_q.blkLeft == 8'h01)) begin
          if (rptReload & lastXfer) begin
            // Restore start address and low count from high
            s_d.memAddr = s_q.memStart;                             // RL8
            s_d.count   = {s_q.count[15:8], s_q.count[15:8]};
          end else begin
            s_d.count = repeatMode ? {s_q.count[15:8], cntNext[7:0]} : cntNext; // RL5 RL7
            if (lastXfer) begin
              s_d.ctrl[dmatms_pkg::CTL_EN] = 1'b0;                  // RL15
              s_d.stat[dmatms_pkg::ST_END] = s_q.ctrl[dmatms_pkg::CTL_IRQEN] | s_q.stat[0];
              evt[dmatms_pkg::ST_END]      = s_q.ctrl[dmatms_pkg::CTL_IRQEN];
            end
          end
        end
      end
      default: s_d.st = dmatms_pkg::ST_IDLE;
    endcase
    // AXI write channels taken in either order
    if (awvalid & ~s_q.awHave & ~s_q.bv) begin
      s_d.awHave = 1'b1;
      s_d.awA    = awaddr;
    end
    if (wvalid & ~s_q.wHave & ~s_q.bv) begin
      s_d.wHave = 1'b1;
      s_d.wD    = wdata;
      s_d.wS    = wstrb;
    end
    // Execute once both halves are held; response raised next edge
    if (s_q.awHave & s_q.wHave & ~s_q.bv) begin
      doW = 1'b1;
      wm  = {{8{s_q.wS[3]}}, {8{s_q.wS[2]}}, {8{s_q.wS[1]}}, {8{s_q.wS[0]}}};
      s_d.awHave = 1'b0;
      s_d.wHave  = 1'b0;
      s_d.bv     = 1'b1;
      s_d.br     = dmatms_pkg::RESP_OKAY;
      case (s_q.awA)
        dmatms_pkg::ADDR_MEM: begin
          s_d.memAddr  = (s_q.memAddr & ~wm[23:0]) | (s_q.wD[23:0] & wm[23:0]);
          s_d.memStart = s_d.memAddr;
        end
        dmatms_pkg::ADDR_IO:    s_d.ioAddr = (s_q.ioAddr & ~wm[15:0]) | (s_q.wD[15:0] & wm[15:0]);
        dmatms_pkg::ADDR_COUNT: s_d.count = (s_q.count & ~wm[15:0]) | (s_q.wD[15:0] & wm[15:0]);
        dmatms_pkg::ADDR_CTRL:  s_d.ctrl = (s_q.ctrl & ~wm[12:0]) | (s_q.wD[12:0] & wm[12:0]);
        dmatms_pkg::ADDR_MASK:  s_d.mask = (s_q.mask & ~wm[1:0]) | (s_q.wD[1:0] & wm[1:0]);
        dmatms_pkg::ADDR_BLOCK: s_d.blkSize = (s_q.blkSize & ~wm[7:0]) | (s_q.wD[7:0] & wm[7:0]);
        // Write one to clear; an event in the same cycle wins
        dmatms_pkg::ADDR_STAT:  s_d.stat = (s_q.stat & ~(s_q.wD[1:0] & wm[1:0])) | evt;
        default: s_d.br = dmatms_pkg::RESP_SLVERR;
      endcase
    end
    // Response handed over
    if (s_q.bv & bready) begin
      s_d.bv = 1'b0;
    end
    // AXI read
    if (arvalid & ~s_q.rv) begin
      s_d.rv = 1'b1;
      s_d.rr = dmatms_pkg::RESP_OKAY;
      case (araddr)
        dmatms_pkg::ADDR_MEM:   s_d.rd = {8'h00, s_q.memAddr};
        dmatms_pkg::ADDR_IO:    s_d.rd = {16'h0000, s_q.ioAddr};
        dmatms_pkg::ADDR_COUNT: s_d.rd = {16'h0000, s_q.count};
        dmatms_pkg::ADDR_CTRL:  s_d.rd = {19'h00000, s_q.ctrl};
        dmatms_pkg::ADDR_STAT:  s_d.rd = {30'h00000000, s_q.stat};
        dmatms_pkg::ADDR_MASK:  s_d.rd = {30'h00000000, s_q.mask};
        dmatms_pkg::ADDR_BLOCK: s_d.rd = {24'h000000, s_q.blkSize};
        default: begin
          s_d.rd = 32'h00000000;
          s_d.rr = dmatms_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_q.rv & rready) begin
      s_d.rv = 1'b0;
    end
    // A control write drops a stale pin request
    if (doW & (s_q.awA == dmatms_pkg::ADDR_CTRL)) begin
      s_d.reqPend = 1'b0;
    end
    // Synchronous reset overrides every update above
    if (~rstn) begin
      s_d = '0;
      s_d.st      = dmatms_pkg::ST_IDLE;
      s_d.ctrl    = dmatms_pkg::CTL_RESET;
      s_d.reqSync = 3'h7; // Idle pin level, no false edge
    end
  end

  //==========================================================================
  // Register the state (synchronous reset folded above)
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  //==========================================================================
  // Outputs
  // Readies fall while a beat is held or a response waits
  assign awready  = ~s_q.awHave & ~s_q.bv;
  assign wready   = ~s_q.wHave & ~s_q.bv;
  assign bvalid   = s_q.bv;
  assign bresp    = s_q.br;
  assign arready  = ~s_q.rv;
  assign rvalid   = s_q.rv;
  assign rdata    = s_q.rd;
  assign rresp    = s_q.rr;
  // Bus cycle strobes follow the state
  assign busRead  = (s_q.st == dmatms_pkg::ST_READ);
  assign busWrite = (s_q.st == dmatms_pkg::ST_WRIT);
  assign busWord  = s_q.ctrl[dmatms_pkg::CTL_WORD];
  assign busWdata = s_q.data;
  // Single address: memory side only, device chosen by acknowledge
  assign busAddr  = singleAddr ? s_q.memAddr
                    : pickAddr(s_q.ctrl[dmatms_pkg::CTL_DIR], busRead, s_q.memAddr, s_q.ioAddr);
  assign transferAcknowledgePinN = ~(singleAddr & busWrite);        // RL9
  // Burst keeps the bus across the whole auto run
  assign busHold  = (s_q.st != dmatms_pkg::ST_IDLE) | s_q.inBlock
                    | (autoReq & s_q.ctrl[dmatms_pkg::CTL_BURST] & s_q.ctrl[dmatms_pkg::CTL_EN]);
  // Level interrupt from unmasked sticky bits
  assign irq      = |(s_q.stat & s_q.mask);
endmodule
`default_nettype wire

// >>> tb/dmatms_bus_model.sv
// Memory and peripheral responder on the system bus, wait states vary
`default_nettype none
module dmatms_bus_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Bus cycle from the sequencer
  input  wire logic [23:0] busAddr,
  input  wire logic        busRead,
  input  wire logic        busWrite,
  // Answer
  output logic      [15:0] busRdata,
  output logic             busDone
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] waitCnt; // Wait states spent
  logic       slow;    // Alternates prompt and slow answers
  // Done pulse after zero or two waits; data churns except in the done cycle
  always @(posedge clk) begin
    if (!rstn) begin
      busDone <= 1'b0;
      waitCnt <= 2'h0;
      slow <= 1'b0;
      busRdata <= 16'hffff;
    end else if (busDone || !(busRead || busWrite)) begin
      busDone <= 1'b0;
      waitCnt <= 2'h0;
      busRdata <= ~busRdata;
    end else if (waitCnt == {slow, 1'b0}) begin
      busDone <= 1'b1;
      slow <= ~slow;
      busRdata <= {8'ha5, busAddr[7:0]};
    end else begin
      waitCnt <= waitCnt + 2'h1;
      busRdata <= ~busRdata;
    end
  end
endmodule
`default_nettype wire

// >>> tb/dmatms_seq_asserts.sv
// Port-level checker for the DMA transfer-mode sequencer
`default_nettype none
module dmatms_seq_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // Register handshakes
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // System bus and strobe
  input wire logic [23:0] busAddr,
  input wire logic        busRead,
  input wire logic        busWrite,
  input wire logic        busDone,
  input wire logic        transferAcknowledgePinN
);
  timeunit 1ns;
  timeprecision 1ns;
  //==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_bus_exclusive: assert property (!(busRead && busWrite))
    else $error("read and write cycles overlap");
  a_read_then_write: assert property (busRead && busDone |=> busWrite)
    else $error("read not followed by write");
  a_read_holds: assert property (busRead && !busDone |=> busRead && $stable(busAddr))
    else $error("read cycle changed early");
  a_write_holds: assert property (busWrite && !busDone |=> busWrite && $stable(busAddr))
    else $error("write cycle changed early");
  a_ack_in_write: assert property (!transferAcknowledgePinN |-> busWrite && !busRead)
    else $error("acknowledge outside a write cycle");
  a_one_item: assert property (busWrite && busDone |=> !busWrite && !busRead)
    else $error("extra item without request");
  a_bvalid_stands: assert property (bvalid && !bready |=> bvalid)
    else $error("write response withdrawn");
  a_rvalid_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data withdrawn");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer late");
endmodule
bind dmatms_seq dmatms_seq_asserts u_chk (.clk(clk), .rstn(rstn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .busAddr(busAddr), .busRead(busRead), .busWrite(busWrite), .busDone(busDone),
  .transferAcknowledgePinN(transferAcknowledgePinN));
`default_nettype wire

// >>> tb/dmatms_seq_tb.sv
// Self-checking bench for the DMA transfer-mode sequencer
`default_nettype none
module dmatms_seq_tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
  typedef struct packed {
    logic [12:0] ctl; logic [23:0] mem; logic [15:0] io; logic [15:0] cnt;
    logic [23:0] endMem; logic msk; logic expIrq;
  } dmatms_row_t;
  // Mode rows: sequential byte, word down swapped, idle masked, single address
  dmatms_row_t rows [4] = '{
    '{13'h0805, 24'h001000, 16'h2000, 16'h0003, 24'h001003, 1'b1, 1'b1},
    '{13'h0839, 24'h004000, 16'h2222, 16'h0002, 24'h003ffc, 1'b1, 1'b0},
    '{13'h0807, 24'h00a000, 16'h3456, 16'h0002, 24'h00a000, 1'b0, 1'b0},
    '{13'h0c01, 24'h00c000, 16'h0100, 16'h0002, 24'h00c002, 1'b1, 1'b0}};
  logic clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic xferReqN = 1, awready, wready, bvalid, arready, rvalid, busRead, busWrite;
  logic busWord, busHold, ackN, irq, busDone;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, lastData;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, resp;
  logic [23:0] busAddr, lastRd, lastWr, m;
  logic [15:0] busWdata, busRdata;
  int fail_count = 0, checks_done = 0, cyc = 0, nRd = 0, nWr = 0, nAck = 0, rd0, a0, w0;
  dmatms_row_t r;
  always #25 clk = ~clk;
  dmatms_seq u_dut (.clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .xferReqN(xferReqN), .busAddr(busAddr), .busRead(busRead), .busWrite(busWrite),
    .busWord(busWord), .busWdata(busWdata), .busRdata(busRdata), .busDone(busDone),
    .busHold(busHold), .transferAcknowledgePinN(ackN), .irq(irq));
  dmatms_bus_model u_mem (.clk(clk), .rstn(rstn), .busAddr(busAddr), .busRead(busRead),
    .busWrite(busWrite), .busRdata(busRdata), .busDone(busDone));
  // Bus monitor on settled values
  always @(negedge clk) begin
    if (busDone && busRead) begin nRd++; lastRd = busAddr; end
    if (busDone && busWrite) begin nWr++; lastWr = busAddr; lastData = busWdata[7:0]; end
    if (!ackN) nAck++;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin fail_count++; conclude(); end
  end
  task automatic conclude();
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Register write: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 0;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready; tw = wvalid && wready; tb = bvalid; resp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end
    bready <= 0;
  endtask
  // Register read
  task automatic axr(input logic [7:0] a);
    logic ta, tr;
    tr = 0;
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid && arready; tr = rvalid; rv = rdata; resp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 0;
    end
    rready <= 0;
  endtask
  // One request pulse, then wait for its write cycle
  task automatic req();
    int w;
    w = nWr + 1;
    xferReqN <= 0;
    repeat (4) @(posedge clk);
    xferReqN <= 1;
    while (nWr < w) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    foreach (rows[i]) begin
      r = rows[i];
      axw(dmatms_pkg::ADDR_MASK, {31'h0, r.msk});
      axw(dmatms_pkg::ADDR_MEM, {8'h0, r.mem});
      axw(dmatms_pkg::ADDR_IO, {16'h0, r.io});
      axw(dmatms_pkg::ADDR_COUNT, {16'h0, r.cnt});
      axw(dmatms_pkg::ADDR_CTRL, {19'h0, r.ctl});
      for (int k = 0; k < int'(r.cnt); k++) begin
        m = (r.ctl[1] && r.ctl[2]) ? r.mem : r.ctl[5] ? r.mem - 24'(k * (r.ctl[4] + 1))
          : r.mem + 24'(k * (r.ctl[4] + 1));
        rd0 = nRd; a0 = nAck;
        req();
        `CHK(busWord, r.ctl[4])
        if (r.ctl[10]) begin
          `CHK(nRd == rd0, 1'b1)
          `CHK(nAck > a0, 1'b1)
          `CHK(lastWr, m)
        end else begin
          `CHK(lastRd, r.ctl[3] ? {8'hff, r.io} : m)
          `CHK(lastWr, r.ctl[3] ? m : {8'hff, r.io})
          `CHK(lastData, lastRd[7:0])
        end
      end
      axr(dmatms_pkg::ADDR_COUNT); `CHK(rv, 32'h0)
      axr(dmatms_pkg::ADDR_CTRL); `CHK(rv[0], 1'b0)
      axr(dmatms_pkg::ADDR_MEM); `CHK(rv[23:0], r.endMem)
      axr(dmatms_pkg::ADDR_IO); `CHK(rv[15:0], r.io)
      axr(dmatms_pkg::ADDR_STAT); `CHK(rv[0], r.ctl[2])
      @(negedge clk); `CHK(irq, r.expIrq)
      axw(dmatms_pkg::ADDR_STAT, 32'h3);
      @(negedge clk); `CHK(irq, 1'b0)
    end
    // Repeat: count of two reloads from the high byte, address restored
    axw(dmatms_pkg::ADDR_MEM, 32'h5000);
    axw(dmatms_pkg::ADDR_COUNT, 32'h0202);
    axw(dmatms_pkg::ADDR_CTRL, 32'h0803);
    repeat (3) req();
    `CHK(lastRd, 24'h005000)
    axr(dmatms_pkg::ADDR_COUNT); `CHK(rv[7:0], 8'h01)
    axr(dmatms_pkg::ADDR_CTRL); `CHK(rv[0], 1'b1)
    // Short-mode A channel ignores the external request pin
    axw(dmatms_pkg::ADDR_COUNT, 32'h1);
    axw(dmatms_pkg::ADDR_CTRL, 32'h0005);
    w0 = nWr;
    xferReqN <= 0;
    repeat (20) @(posedge clk);
    xferReqN <= 1;
    `CHK(nWr == w0, 1'b1)
    axr(dmatms_pkg::ADDR_COUNT); `CHK(rv, 32'h1)
    // Full address auto-request burst runs the whole count unprompted
    axw(dmatms_pkg::ADDR_MEM, 32'h6000);
    axw(dmatms_pkg::ADDR_IO, 32'h1234);
    axw(dmatms_pkg::ADDR_COUNT, 32'h3);
    w0 = nWr;
    axw(dmatms_pkg::ADDR_CTRL, 32'h0341);
    @(negedge clk); `CHK(busHold, 1'b1)
    while (nWr < w0 + 3) @(posedge clk);
    repeat (3) @(posedge clk);
    `CHK(nWr - w0, 3)
    `CHK(lastWr, 24'hff1234)
    @(negedge clk); `CHK(busHold, 1'b0)
    axr(dmatms_pkg::ADDR_COUNT); `CHK(rv, 32'h0)
    axr(dmatms_pkg::ADDR_CTRL); `CHK(rv[0], 1'b0)
    axr(dmatms_pkg::ADDR_MEM); `CHK(rv[23:0], 24'h006003)
    // Block mode: one request moves a whole block of two
    axw(dmatms_pkg::ADDR_BLOCK, 32'h2);
    axw(dmatms_pkg::ADDR_COUNT, 32'h1);
    axw(dmatms_pkg::ADDR_CTRL, 32'h00c1);
    w0 = nWr;
    req();
    while (nWr < w0 + 2) @(posedge clk);
    repeat (10) @(posedge clk);
    `CHK(nWr - w0, 2)
    axr(dmatms_pkg::ADDR_COUNT); `CHK(rv, 32'h0)
    // Unmapped addresses
    axr(8'h1c); `CHK({resp, rv}, {dmatms_pkg::RESP_SLVERR, 32'h0})
    axw(8'h20, 32'h1); `CHK(resp, dmatms_pkg::RESP_SLVERR)
    // Second reset clears the control register
    rstn <= 0;
    repeat (10) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    axr(dmatms_pkg::ADDR_CTRL); `CHK(rv, 32'h0)
    conclude();
  end
endmodule
`default_nettype wire
